/* File: include/fss_pkg.sv */
// package of constants for the fuse and signature store
// Function
// RULE1: programmed fuse bit reads as zero, unprogrammed as one.
// RULE2: exactly three eight-bit fuse bytes: extended, high and low.
// RULE3: extended bit 0 allows self-programming; bits 7:1 unused, read one.
// RULE4: high byte: reset disable, debug, serial download, watchdog, preserve, brown-out.
// RULE5: low byte: divide by eight, clock out, start-up, clock source.
// RULE6: programmed clock-output fuse drives system clock onto clock-output pin; the code drives a half-rate registered toggle instead.
// RULE7: default start-up setting gives longest delay for default clock source.
// RULE8: serial-download fuse neither read nor written in serial programming mode.
// RULE9: reset-disable or debug fuse programmed leaves only high-voltage programming; the code still lets serial mode chip-erase the lock bits.
// RULE10: programmer leaves debug fuse unprogrammed when lock protection is needed.
// RULE11: while lock bit one is programmed, fuse changes are rejected.
// RULE12: programmer should write fuses before lock bits.
// RULE13: chip erase leaves every fuse bit unchanged.
// RULE14: fuses latched on programming entry; writes act only after leaving.
// RULE15: preserve-data fuse acts immediately, even inside programming mode.
// RULE16: fuses captured into working latches at every power-up.
// RULE17: imprint map: ids at 0,2,4; calibrations at 1 and 3; rest reserved.
// RULE18: identity bytes readable in both programming modes, even when locked.
// RULE19: firmware can read identity bytes, calibration bytes and lock bits.
// RULE20: in normal mode reset copies 8 MHz calibration into trim register.
// RULE21: in legacy mode reset copies 6.4 MHz calibration instead.
// RULE22: load within three cycles after fuse-read plus store-enable returns lock/fuse.
// RULE23: load within three cycles after imprint-read plus store-enable returns table byte.
// RULE24: working latches stay stable between latch events.
package fss_pkg;
   // ************************************************************
   // fuse byte selectors and reset values
   // ************************************************************
   localparam logic [1:0] SEL_LOW        = 2'h0;
   localparam logic [1:0] SEL_HIGH       = 2'h1;
   localparam logic [1:0] SEL_EXT        = 2'h2;
   localparam logic [1:0] SEL_LOCK       = 2'h3;
   localparam logic [7:0] RST_EXT        = 8'h00_FF;
   localparam logic [7:0] RST_HIGH       = 8'h00_DF;
   localparam logic [7:0] RST_LOW        = 8'h00_62;
   localparam logic [7:0] RST_LOCK       = 8'h00_FF;
   localparam logic [7:0] RST_TRIM       = 8'h00_80;
   // field positions
   localparam int BIT_SELF_PROG          = 0;
   localparam int BIT_RST_DIS            = 7;
   localparam int BIT_DEBUG              = 6;
   localparam int BIT_SERIAL_DL          = 5;
   localparam int BIT_WDOG               = 4;
   localparam int BIT_PRESERVE           = 3;
   localparam int BIT_DIV8               = 7;
   localparam int BIT_CLKOUT             = 6;
   localparam int BIT_LOCK1              = 0;
   // firmware control byte bit positions
   localparam int BIT_FW_STORE           = 0;
   localparam int BIT_FW_FUSE            = 3;
   localparam int BIT_FW_SIG             = 5;
   // imprint table offsets
   localparam logic [5:0] OFS_SIG0       = 6'h00;
   localparam logic [5:0] OFS_CAL8       = 6'h01;
   localparam logic [5:0] OFS_SIG1       = 6'h02;
   localparam logic [5:0] OFS_CAL64      = 6'h03;
   localparam logic [5:0] OFS_SIG2       = 6'h04;
   localparam logic [5:0] OFS_RSVD_LAST  = 6'h2A;
   // window after a read-enable write, in cycles
   localparam logic [1:0] READ_WIN_CYC   = 2'h3;
endpackage

/* File: hdl/fss_store.sv */
// fuse and signature store with working latches and firmware read path
`timescale 1ns/1ps
module fss_store
   import fss_pkg::*;
#(
   parameter logic [7:0] SIG_BYTE0  = 8'h00_A5, // arbitrary identity value
   parameter logic [7:0] SIG_BYTE1  = 8'h00_5A, // arbitrary identity value
   parameter logic [7:0] SIG_BYTE2  = 8'h00_3C, // arbitrary identity value
   parameter logic [7:0] CAL_8MHZ   = 8'h00_80,
   parameter logic [7:0] CAL_6P4MHZ = 8'h00_70
)(
   input  wire logic       clk_sys_in,
   input  wire logic       arst_n_in,
   input  wire logic       prog_serial_in,
   input  wire logic       prog_hv_in,
   input  wire logic       legacy_mode_in,
   input  wire logic       fuse_wr_in,
   input  wire logic [1:0] fuse_sel_in,
   input  wire logic [7:0] fuse_wdata_in,
   input  wire logic       chip_erase_in,
   input  wire logic       prog_rd_in,
   input  wire logic [1:0] prog_rd_kind_in,
   input  wire logic [5:0] prog_addr_in,
   input  wire logic       fw_ctrl_wr_in,
   input  wire logic [7:0] fw_ctrl_in,
   input  wire logic       fw_load_in,
   input  wire logic [5:0] fw_ptr_in,
   output logic [7:0]      prog_rdata_out,
   output logic [7:0]      fw_rdata_out,
   output logic            fw_rvalid_out,
   output logic [7:0]      oscillator_trim_register_out,
   output logic [7:0]      fuse_ext_out,
   output logic [7:0]      fuse_high_out,
   output logic [7:0]      fuse_low_out,
   output logic            erase_preserve_data_out,
   output logic            hv_only_out,
   output logic            clk_out_out
);
   // ************************************************************
   // pin synchronisers: three stages, change when stages 2 and 3 agree
   // ************************************************************
   logic [2:0] ser_sy_ff, hv_sy_ff;
   logic       ser_ff, hv_ff;
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ser_sy_ff <= 3'h0;
         hv_sy_ff  <= 3'h0;
         ser_ff    <= 1'b0;
         hv_ff     <= 1'b0;
      end else begin
         ser_sy_ff <= {ser_sy_ff[1:0], prog_serial_in};
         hv_sy_ff  <= {hv_sy_ff[1:0], prog_hv_in};
         if (ser_sy_ff[1] == ser_sy_ff[2]) ser_ff <= ser_sy_ff[2];
         if (hv_sy_ff[1] == hv_sy_ff[2]) hv_ff <= hv_sy_ff[2];
      end
   end

   // ************************************************************
   // nonvolatile fuse and lock cells
   // ************************************************************
   // cells are never reset: only writes and chip erase change them, start-up holds the shipped state
   logic [7:0] nv_ext_ff  = RST_EXT;                                  // see RULE2 see RULE3
   logic [7:0] nv_high_ff = RST_HIGH;                                 // see RULE4
   logic [7:0] nv_low_ff  = RST_LOW;                                  // see RULE5 see RULE7
   logic [7:0] nv_lock_ff = RST_LOCK;
   logic       prog_mode, prog_mode_d_ff, enter_prog, leave_prog;
   logic       lock1_set, hv_blocked, wr_ok, wr_ext, wr_high, wr_low;
   logic [7:0] nxt_high;
   assign prog_mode  = ser_ff | hv_ff;
   assign enter_prog = prog_mode & ~prog_mode_d_ff;
   assign leave_prog = ~prog_mode & prog_mode_d_ff;
   assign lock1_set  = ~nv_lock_ff[BIT_LOCK1];                        // see RULE1
   // serial fuse reads and writes are shut out once reset-disable or debug is latched programmed
   assign hv_blocked = hv_only_out & ser_ff;                          // see RULE9
   // locked fuses refuse every write; chip erase has no path here
   assign wr_ok   = fuse_wr_in & prog_mode & ~lock1_set & ~hv_blocked; // see RULE11 see RULE13
   assign wr_ext  = wr_ok & (fuse_sel_in == SEL_EXT);
   assign wr_high = wr_ok & (fuse_sel_in == SEL_HIGH);
   assign wr_low  = wr_ok & (fuse_sel_in == SEL_LOW);
   // serial mode cannot touch the serial-download bit
   assign nxt_high = ser_ff ?
      {fuse_wdata_in[7:6], nv_high_ff[BIT_SERIAL_DL], fuse_wdata_in[4:0]} :
      fuse_wdata_in;                                                  // see RULE8
   // unused extended bits forced unprogrammed; no reset, a reset must not wipe fuses
   always_ff @(posedge clk_sys_in) begin
      if (wr_ext) nv_ext_ff <= {7'h7F, fuse_wdata_in[BIT_SELF_PROG]};    // see RULE3
      if (wr_high) nv_high_ff <= nxt_high;
      if (wr_low) nv_low_ff <= fuse_wdata_in;
      if (chip_erase_in & prog_mode) nv_lock_ff <= RST_LOCK;
      else if (wr_ok & (fuse_sel_in == SEL_LOCK)) nv_lock_ff <= fuse_wdata_in;
   end

   // ************************************************************
   // working latches: loaded at power-up and at programming entry and exit
   // ************************************************************
   logic latch_ev;
   logic pwr_up_ff;
   // exit is an event too so post-session writes apply after leaving
   assign latch_ev = enter_prog | leave_prog | pwr_up_ff;             // see RULE14 see RULE16
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pwr_up_ff      <= 1'b1;
         prog_mode_d_ff <= 1'b0;
         fuse_ext_out   <= RST_EXT;
         fuse_high_out  <= RST_HIGH;
         fuse_low_out   <= RST_LOW;
      end else begin
         pwr_up_ff      <= 1'b0;
         prog_mode_d_ff <= prog_mode;
         if (latch_ev) begin                                          // see RULE24
            fuse_ext_out  <= nv_ext_ff;
            fuse_high_out <= nv_high_ff;
            fuse_low_out  <= nv_low_ff;
         end
      end
   end

   // ************************************************************
   // immediate fuses and derived outputs
   // ************************************************************
   logic preserve_now, hv_only_now;
   // preserve bit bypasses the latch, tracking the cell directly
   assign preserve_now = ~nv_high_ff[BIT_PRESERVE];                   // see RULE15
   assign hv_only_now  = ~fuse_high_out[BIT_RST_DIS] | ~fuse_high_out[BIT_DEBUG]; // see RULE9
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         erase_preserve_data_out <= 1'b0;
         hv_only_out             <= 1'b0;
         clk_out_out             <= 1'b0;
      end else begin
         erase_preserve_data_out <= preserve_now;
         hv_only_out             <= hv_only_now;
         // registered toggle follows the system clock at half rate
         clk_out_out <= ~fuse_low_out[BIT_CLKOUT] & ~clk_out_out;     // see RULE6
      end
   end

   // ************************************************************
   // imprint table lookup
   // ************************************************************
   function automatic logic [7:0] imprint(input logic [5:0] a);
      case (a)
         OFS_SIG0:  imprint = SIG_BYTE0;                              // see RULE17
         OFS_CAL8:  imprint = CAL_8MHZ;
         OFS_SIG1:  imprint = SIG_BYTE1;
         OFS_CAL64: imprint = CAL_6P4MHZ;
         OFS_SIG2:  imprint = SIG_BYTE2;
         default:   imprint = 8'h00;
      endcase
   endfunction

   // ************************************************************
   // programmer read port: kinds 0 low,1 high,2 ext,3 imprint
   // ************************************************************
   logic [7:0] prog_fuse_rd, prog_rd_val;
   assign prog_fuse_rd = (prog_rd_kind_in == SEL_LOW)  ? nv_low_ff :
                         (prog_rd_kind_in == SEL_HIGH) ?
                         (ser_ff ? (nv_high_ff | 8'h20) : nv_high_ff) : // see RULE8
                         nv_ext_ff;
   // identity bytes ignore lock state entirely
   assign prog_rd_val = (prog_rd_kind_in == SEL_LOCK) ? imprint(prog_addr_in) :
                        hv_blocked ? 8'h00_FF : prog_fuse_rd;          // see RULE18
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) prog_rdata_out <= 8'h00;
      else if (prog_rd_in & prog_mode) prog_rdata_out <= prog_rd_val;
   end

   // ************************************************************
   // firmware read path: enable bits open a three-cycle window
   // ************************************************************
   logic [1:0] win_cnt_ff;
   logic       win_fuse_ff, win_sig_ff, arm_fuse, arm_sig, hit;
   logic [7:0] fw_fuse_val, fw_val;
   assign arm_fuse = fw_ctrl_wr_in & fw_ctrl_in[BIT_FW_FUSE] & fw_ctrl_in[BIT_FW_STORE];
   assign arm_sig  = fw_ctrl_wr_in & fw_ctrl_in[BIT_FW_SIG] & fw_ctrl_in[BIT_FW_STORE];
   // a window opened by neither read kind answers nothing
   assign hit      = fw_load_in & (win_cnt_ff != 2'h0) & (win_fuse_ff | win_sig_ff);
   // pointer selects 0 lock bits, 1 low, 2 extended, 3 high fuse byte
   assign fw_fuse_val = ~fw_ptr_in[0] ? (fw_ptr_in[1] ? nv_ext_ff : nv_lock_ff) :
                        (fw_ptr_in[1] ? nv_high_ff : nv_low_ff);      // see RULE22 see RULE19
   assign fw_val = win_sig_ff ? imprint(fw_ptr_in) : fw_fuse_val;     // see RULE23
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         win_cnt_ff    <= 2'h0;
         win_fuse_ff   <= 1'b0;
         win_sig_ff    <= 1'b0;
         fw_rdata_out  <= 8'h00;
         fw_rvalid_out <= 1'b0;
      end else begin
         fw_rvalid_out <= hit;
         if (hit) fw_rdata_out <= fw_val;
         if (arm_fuse | arm_sig) begin
            win_cnt_ff  <= READ_WIN_CYC;
            win_fuse_ff <= arm_fuse & ~arm_sig;
            win_sig_ff  <= arm_sig;
         end else if (hit) begin
            win_cnt_ff <= 2'h0;
         end else if (win_cnt_ff != 2'h0) begin
            win_cnt_ff <= win_cnt_ff - 2'h1;
         end
      end
   end

   // ************************************************************
   // oscillator trim load during reset window
   // ************************************************************
   logic [7:0] trim_src;
   assign trim_src = legacy_mode_in ? CAL_6P4MHZ : CAL_8MHZ;          // see RULE20 see RULE21
   // legacy strap sampled by clock at first edge after release
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) oscillator_trim_register_out <= RST_TRIM;
      else if (pwr_up_ff) oscillator_trim_register_out <= trim_src;
   end

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_arm;
      arm_fuse | arm_sig;
   endsequence
   a_window_hit_valid: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      s_arm ##1 fw_load_in |=> fw_rvalid_out)                          // see RULE22
      else $error("load inside window gave no data");
   a_sig_read_data: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      arm_sig ##1 (fw_load_in && fw_ptr_in == OFS_SIG0) |=> fw_rdata_out == SIG_BYTE0) // see RULE23
      else $error("identity byte read wrong");
   a_no_late_load: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      (win_cnt_ff == 2'h0 && fw_load_in) |=> !fw_rvalid_out)
      else $error("load outside window answered");
   a_locked_fuse_hold: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      lock1_set && !chip_erase_in |=> $stable(nv_low_ff) && $stable(nv_high_ff)) // see RULE11
      else $error("locked fuse changed");
   a_latch_stable: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      !latch_ev |=> $stable(fuse_low_out) && $stable(fuse_high_out))  // see RULE24
      else $error("working latch moved without event");
   a_prog_write_deferred: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      prog_mode && prog_mode_d_ff && wr_low ##1 prog_mode |=> $stable(fuse_low_out)) // see RULE14
      else $error("fuse write acted inside programming");
   a_preserve_now: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE15
      wr_high |=> ##1 erase_preserve_data_out == !$past(fuse_wdata_in[BIT_PRESERVE], 2))
      else $error("preserve fuse not immediate");
   a_serial_dl_kept: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      wr_high && ser_ff |=> nv_high_ff[BIT_SERIAL_DL] == $past(nv_high_ff[BIT_SERIAL_DL])) // see RULE8
      else $error("serial download bit changed in serial mode");
   a_erase_keeps_fuse: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      chip_erase_in && !fuse_wr_in |=> $stable(nv_ext_ff) && $stable(nv_low_ff)) // see RULE13
      else $error("chip erase altered fuse");
   a_trim_source: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE20
      pwr_up_ff |=> oscillator_trim_register_out ==
         ($past(legacy_mode_in) ? CAL_6P4MHZ : CAL_8MHZ))          // see RULE21
      else $error("trim not loaded from calibration");
   a_hv_only_write: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE9
      hv_blocked && fuse_wr_in |=> $stable(nv_low_ff) && $stable(nv_high_ff))
      else $error("fuse written through serial after lockout");
   a_ext_unused_one: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE3
      nv_ext_ff[7:1] == 7'h7F)
      else $error("unused extended fuse bit programmed");
   a_enter_latch: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE14
      enter_prog |=> fuse_low_out == $past(nv_low_ff) && fuse_high_out == $past(nv_high_ff))
      else $error("fuses not latched on programming entry");
   a_powerup_latch: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE16
      pwr_up_ff |=> fuse_high_out == $past(nv_high_ff) && fuse_ext_out == $past(nv_ext_ff))
      else $error("fuses not captured at power-up");
   a_clkout_idle: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE6
      fuse_low_out[BIT_CLKOUT] |=> !clk_out_out)
      else $error("clock output driven while fuse unprogrammed");
   a_serial_dl_read: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE8
      prog_rd_in && prog_mode && ser_ff && !hv_blocked && prog_rd_kind_in == SEL_HIGH
      |=> prog_rdata_out[BIT_SERIAL_DL])
      else $error("serial download bit visible in serial mode");
   a_id_read_locked: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE18
      prog_rd_in && prog_mode && lock1_set && prog_rd_kind_in == SEL_LOCK
      && prog_addr_in == OFS_SIG2 |=> prog_rdata_out == SIG_BYTE2)
      else $error("identity byte hidden by lock");
   // load may come on any of the three window cycles
   sequence s_fuse_low_load;
      arm_fuse && !arm_sig ##[1:3]
      (fw_load_in && win_cnt_ff != 2'h0 && win_fuse_ff && fw_ptr_in[1:0] == 2'h1);
   endsequence
   a_fuse_read_data: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // see RULE22
      s_fuse_low_load |=> fw_rdata_out == $past(nv_low_ff))
      else $error("low fuse read wrong");
endmodule

/* File: bench/fss_prog_model.sv */
// external programmer model: mode pins, fuse and lock writes, erase, reads
`timescale 1ns/1ps
module fss_prog_model (
   input  wire logic       clk_sys_in,
   input  wire logic [7:0] prog_rdata_in,
   output logic            prog_serial_out,
   output logic            prog_hv_out,
   output logic            fuse_wr_out,
   output logic [1:0]      fuse_sel_out,
   output logic [7:0]      fuse_wdata_out,
   output logic            chip_erase_out,
   output logic            prog_rd_out,
   output logic [1:0]      prog_rd_kind_out,
   output logic [5:0]      prog_addr_out
);
   // ************************************************************
   // programmer side, driven on the falling edge
   // ************************************************************
   // idle levels at time zero, no mode pin raised
   initial begin
      {prog_serial_out, prog_hv_out, fuse_wr_out, chip_erase_out, prog_rd_out} = 5'h00_00;
      fuse_sel_out = 2'h0;
      fuse_wdata_out = 8'h00_00;
      prog_rd_kind_out = 2'h0;
      prog_addr_out = 6'h00;
   end
   // mode pins pass a 3-flop sync, so give them 6 cycles to settle
   task automatic set_mode(input logic ser, input logic hv);
      @(negedge clk_sys_in);
      prog_serial_out = ser;
      prog_hv_out = hv;
      repeat (6) @(negedge clk_sys_in);
   endtask
   // one-cycle strobe; released data shows its inverse, never a stale copy
   task automatic write(input logic [1:0] sel, input logic [7:0] data, input logic erase);
      @(negedge clk_sys_in);
      fuse_wr_out = ~erase;
      chip_erase_out = erase;
      fuse_sel_out = sel;
      fuse_wdata_out = data;
      @(negedge clk_sys_in);
      fuse_wr_out = 1'b0;
      chip_erase_out = 1'b0;
      fuse_wdata_out = ~data;
   endtask
   // read data lands on the edge that takes the strobe
   task automatic read(input logic [1:0] kind, input logic [5:0] addr, output logic [7:0] data);
      @(negedge clk_sys_in);
      prog_rd_out = 1'b1;
      prog_rd_kind_out = kind;
      prog_addr_out = addr;
      @(negedge clk_sys_in);
      prog_rd_out = 1'b0;
      prog_addr_out = ~addr;
      data = prog_rdata_in;
   endtask
endmodule

/* File: bench/fss_store_tb.sv */
// self-checking testbench of the fuse and signature store
`timescale 1ns/1ps
`define CHK(nm, exp, act) begin samples_checked++; if ((act) !== (exp)) begin n_errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, act); end end
module fss_store_tb
   import fss_pkg::*;
;
   // ************************************************************
   // signals, design and programmer
   // ************************************************************
   localparam logic [7:0] S0 = 8'h00_C3; // arbitrary identity value
   localparam logic [7:0] S1 = 8'h00_4B; // arbitrary identity value
   localparam logic [7:0] S2 = 8'h00_E1; // arbitrary identity value
   localparam logic [7:0] C8 = 8'h00_9A;
   localparam logic [7:0] C6 = 8'h00_6D;
   logic [7:0] img [6] = '{S0, C8, S1, C6, S2, 8'h00_00};
   logic [7:0] fz [4] = '{8'h00_FF, 8'h00_62, 8'h00_FF, 8'h00_DF};
   logic clk_sys_in = 1'b0, arst_n_in = 1'b0, legacy_mode_in = 1'b0;
   logic fw_ctrl_wr_in = 1'b0, fw_load_in = 1'b0, a;
   logic [7:0] fw_ctrl_in = 8'h00_00, d;
   logic [5:0] fw_ptr_in = 6'h00;
   logic prog_serial_in, prog_hv_in, fuse_wr_in, chip_erase_in, prog_rd_in;
   logic [1:0] fuse_sel_in, prog_rd_kind_in;
   logic [7:0] fuse_wdata_in, prog_rdata_out, fw_rdata_out, oscillator_trim_register_out;
   logic [7:0] fuse_ext_out, fuse_high_out, fuse_low_out;
   logic [5:0] prog_addr_in;
   logic fw_rvalid_out, erase_preserve_data_out, hv_only_out, clk_out_out;
   int n_errors = 0, samples_checked = 0, cycles = 0;
   fss_store #(.SIG_BYTE0(S0), .SIG_BYTE1(S1), .SIG_BYTE2(S2), .CAL_8MHZ(C8), .CAL_6P4MHZ(C6))
   fss_store_inst (.clk_sys_in, .arst_n_in, .prog_serial_in, .prog_hv_in, .legacy_mode_in,
      .fuse_wr_in, .fuse_sel_in, .fuse_wdata_in, .chip_erase_in, .prog_rd_in, .prog_rd_kind_in,
      .prog_addr_in, .fw_ctrl_wr_in, .fw_ctrl_in, .fw_load_in, .fw_ptr_in, .prog_rdata_out,
      .fw_rdata_out, .fw_rvalid_out, .oscillator_trim_register_out, .fuse_ext_out,
      .fuse_high_out, .fuse_low_out, .erase_preserve_data_out, .hv_only_out, .clk_out_out);
   fss_prog_model fss_prog_model_inst (.clk_sys_in(clk_sys_in), .prog_rdata_in(prog_rdata_out),
      .prog_serial_out(prog_serial_in), .prog_hv_out(prog_hv_in), .fuse_wr_out(fuse_wr_in),
      .fuse_sel_out(fuse_sel_in), .fuse_wdata_out(fuse_wdata_in),
      .chip_erase_out(chip_erase_in), .prog_rd_out(prog_rd_in),
      .prog_rd_kind_out(prog_rd_kind_in), .prog_addr_out(prog_addr_in));
   // ************************************************************
   // clock, watchdog and tasks
   // ************************************************************
   // 20 MHz system clock
   always #25 clk_sys_in = ~clk_sys_in;
   // the run needs some 200 cycles; a hang is cut at 3000
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // strap is sampled on the first edge after release; requests from edge 4
   task automatic reset_dut(input logic legacy);
      @(negedge clk_sys_in);
      arst_n_in = 1'b0;
      legacy_mode_in = legacy;
      repeat (20) @(negedge clk_sys_in);
      arst_n_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
   endtask
   // arm, then load dly cycles later; the answer stands one cycle
   task automatic fw_read(input logic [7:0] ctrl, input logic [5:0] ptr, input int dly,
                          input logic ok, input logic [7:0] exp);
      @(negedge clk_sys_in);
      fw_ctrl_wr_in = 1'b1;
      fw_ctrl_in = ctrl;
      @(negedge clk_sys_in);
      fw_ctrl_wr_in = 1'b0;
      repeat (dly - 1) @(negedge clk_sys_in);
      fw_load_in = 1'b1;
      fw_ptr_in = ptr;
      @(negedge clk_sys_in);
      fw_load_in = 1'b0;
      fw_ptr_in = ~ptr;
      `CHK("fw_rvalid", ok, fw_rvalid_out)
      if (ok) `CHK("fw_rdata", exp, fw_rdata_out)
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      reset_dut(1'b0);
      `CHK("fuse_ext", 8'h00_FF, fuse_ext_out)
      `CHK("fuse_high", 8'h00_DF, fuse_high_out)
      `CHK("fuse_low", 8'h00_62, fuse_low_out)
      `CHK("trim", C8, oscillator_trim_register_out)
      `CHK("clk_out", 1'b0, clk_out_out)
      $display("test defaults done");
      for (int i = 0; i < 6; i++) fw_read(8'h00_21, 6'(i), (i % 3) + 1, 1'b1, img[i]);
      fw_read(8'h00_21, 6'h2A, 3, 1'b1, 8'h00_00);
      for (int i = 0; i < 4; i++) fw_read(8'h00_09, 6'(i), 2, 1'b1, fz[i]);
      fw_read(8'h00_21, 6'h00, 4, 1'b0, 8'h00_00);
      $display("test firmware reads done");
      // writes in high-voltage mode wait for the exit latch, preserve acts at once
      fss_prog_model_inst.set_mode(1'b0, 1'b1);
      fss_prog_model_inst.write(SEL_LOW, 8'h00_22, 1'b0);
      fss_prog_model_inst.write(SEL_HIGH, 8'h00_D7, 1'b0);
      @(negedge clk_sys_in);
      `CHK("preserve", 1'b1, erase_preserve_data_out)
      `CHK("fuse_low_held", 8'h00_62, fuse_low_out)
      fss_prog_model_inst.write(SEL_LOW, 8'h00_00, 1'b1);
      fss_prog_model_inst.read(2'h0, 6'h00, d);
      `CHK("low_after_erase", 8'h00_22, d)
      fss_prog_model_inst.set_mode(1'b0, 1'b0);
      `CHK("fuse_low_new", 8'h00_22, fuse_low_out)
      a = clk_out_out;
      @(negedge clk_sys_in);
      `CHK("clk_out_toggle", 1'b1, a ^ clk_out_out)
      $display("test latching done");
      // serial mode leaves the download fuse alone and shows it as one
      fss_prog_model_inst.set_mode(1'b1, 1'b0);
      fss_prog_model_inst.write(SEL_HIGH, 8'h00_F7, 1'b0);
      fss_prog_model_inst.read(2'h1, 6'h00, d);
      `CHK("high_serial", 8'h00_F7, d)
      fss_prog_model_inst.set_mode(1'b0, 1'b1);
      fss_prog_model_inst.read(2'h1, 6'h00, d);
      `CHK("high_hv", 8'h00_D7, d)
      $display("test serial download fuse done");
      // the lock goes on first, so the low fuse write after it is refused
      fss_prog_model_inst.write(SEL_LOCK, 8'h00_FE, 1'b0);
      fss_prog_model_inst.write(SEL_LOW, 8'h00_62, 1'b0);
      fss_prog_model_inst.read(2'h0, 6'h00, d);
      `CHK("low_locked", 8'h00_22, d)
      fss_prog_model_inst.read(2'h3, 6'h04, d);
      `CHK("id_hv_locked", S2, d)
      fss_prog_model_inst.set_mode(1'b1, 1'b0);
      fss_prog_model_inst.read(2'h3, 6'h00, d);
      `CHK("id_serial_locked", S0, d)
      fss_prog_model_inst.write(SEL_LOW, 8'h00_00, 1'b1);
      // debug fuse only programmed once the lock is cleared
      fss_prog_model_inst.write(SEL_HIGH, 8'h00_97, 1'b0);
      fss_prog_model_inst.set_mode(1'b0, 1'b0);
      `CHK("hv_only", 1'b1, hv_only_out)
      fss_prog_model_inst.set_mode(1'b1, 1'b0);
      fss_prog_model_inst.read(2'h2, 6'h00, d);
      `CHK("serial_refused", 8'h00_FF, d)
      fss_prog_model_inst.write(SEL_LOW, 8'h00_62, 1'b0);
      fss_prog_model_inst.set_mode(1'b0, 1'b1);
      fss_prog_model_inst.read(2'h0, 6'h00, d);
      `CHK("low_hv_only", 8'h00_22, d)
      fss_prog_model_inst.set_mode(1'b0, 1'b0);
      $display("test lock and debug done");
      reset_dut(1'b1);
      `CHK("trim_legacy", C6, oscillator_trim_register_out)
      `CHK("high_powerup", 8'h00_97, fuse_high_out)
      $display("test legacy reset done");
      finish_test();
   end
endmodule
